//--- inc/utility_pkg.sv
// Constants for the bus timeout and lockout utility register block
package utility_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] UTIL_OFFSET = 8'h20;
    localparam int CAP_POS = 28;
    localparam int HOLD_POS = 24;
    localparam int ABORT_POS = 20;
    localparam int MAP_POS = 18;
    localparam int NARROW_POS = 17;
    localparam logic [3:0] CAP_RESET = 4'h4;
    localparam logic [3:0] HOLD_RESET = 4'h3;
    localparam logic [3:0] ABORT_RESET = 4'hF;
    localparam logic [1:0] MAP_RESET = 2'h0;
    localparam logic NARROW_RESET = 1'b0;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // ==========================================================
    // Translation modes
    typedef enum logic [1:0] {
        MAP_NONE = 2'b00,
        MAP_PAGE512 = 2'b01,
        MAP_PAGE4K = 2'b10,
        MAP_PAGE8K = 2'b11
    } map_mode_t;
    localparam int ADDR_W = 40;
    localparam int NARROW_MASK_BITS = 5;

    // ==========================================================
    // Timing
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int LONG_TICK_US = 1000;
    localparam int SHORT_TICK_US = 64;
    localparam int LONG_TICK_CYCLES = LONG_TICK_US * 1000 / CLOCK_PERIOD_NS;
    localparam int SHORT_TICK_CYCLES =
        SHORT_TICK_US * 1000 / CLOCK_PERIOD_NS;

    // ==========================================================
    // Lockout state machine
    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_HOLD = 2'b01,
        LK_RELEASED = 2'b11
    } lock_state_t;
endpackage : utility_pkg

//--- rtl/tick_gen.sv
// Free-running long and short timer tick divider
`timescale 1ns/1ps
module tick_gen #(
    parameter int LONG_CYCLES = utility_pkg::LONG_TICK_CYCLES,
    parameter int SHORT_CYCLES = utility_pkg::SHORT_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Ticks
    output logic longTick,
    output logic shortTick
);
    import utility_pkg::*;

    logic [15:0] longCnt_q, longCnt_d;
    logic [15:0] shortCnt_q, shortCnt_d;
    logic longTick_q, longTick_d;
    logic shortTick_q, shortTick_d;

    // ==========================================================
    // Dividers
    always_comb begin
        longTick_d = (longCnt_q == 16'(LONG_CYCLES - 1));
        shortTick_d = (shortCnt_q == 16'(SHORT_CYCLES - 1));
        longCnt_d = longTick_d ? 16'h0000 : longCnt_q + 16'h0001;
        shortCnt_d = shortTick_d ? 16'h0000 : shortCnt_q + 16'h0001;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            longCnt_q <= 16'h0000;
            shortCnt_q <= 16'h0000;
            longTick_q <= 1'b0;
            shortTick_q <= 1'b0;
        end else begin
            longCnt_q <= longCnt_d;
            shortCnt_q <= shortCnt_d;
            longTick_q <= longTick_d;
            shortTick_q <= shortTick_d;
        end
    end

    assign longTick = longTick_q;
    assign shortTick = shortTick_q;
endmodule : tick_gen

//--- rtl/bus_timeout_lockout_utility.sv
// Utility register with interlocked-read lockout and transaction timers
// Overview of operation
// - Retry cap limits interlocked reads before lockout
// - Retry cap resets to four
// - Cap zero or one means one attempt
// - Hold release time bounds lockout assertion
// - Hold value n gives n-1 to n ms
// - Abort limit times out retry and read wait
// - Short timeout enable picks 64 us steps
// - Abort value n gives n-1 to n steps
// - Abort limit resets to F
// - Map mode field selects translation mode
// - Map mode resets to no translation
// - Bit 17 enables narrow address mode
// - Register decoded at offset 0x20
// - Narrow mode zeroes top five bits, 512-byte only
// - Reserved bits read zero, writes ignored
`timescale 1ns/1ps
module bus_timeout_lockout_utility #(
    parameter int LONG_CYCLES = utility_pkg::LONG_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register access
    input wire logic regSel,
    input wire logic regWr,
    input wire logic [7:0] regOffset,
    input wire logic [31:0] regWrData,
    output logic [31:0] regRdData,
    output logic regAck,
    // Control from the control status register
    input wire logic shortTimeoutEnable,
    // Interlocked read events
    input wire logic interlockedRdRetry,
    input wire logic interlockedRdDone,
    output logic bus_hold_off_n,
    // Transaction timer
    input wire logic txnStart,
    input wire logic txnEnd,
    output logic txnAbort,
    output logic transaction_expired_flag,
    input wire logic expiredFlagClear,
    // Address translation
    input wire logic [utility_pkg::ADDR_W-1:0] xlatAddrIn,
    output logic [utility_pkg::ADDR_W-1:0] xlatAddrOut,
    output utility_pkg::map_mode_t map_mode_select,
    output logic narrow_address_enable
);
    import utility_pkg::*;

    // Value 0 and 1 both mean one step
    function automatic logic [3:0] stepCount(input logic [3:0] v);
        stepCount = (v <= 4'h1) ? 4'h1 : v;
    endfunction : stepCount

    // ==========================================================
    // Tick source
    logic longTick, shortTick, abortTick;

    tick_gen #(
        .LONG_CYCLES(LONG_CYCLES),
        .SHORT_CYCLES(SHORT_TICK_CYCLES)
    ) u_tick (
        .clock(clock),
        .sys_rst(sys_rst),
        .longTick(longTick),
        .shortTick(shortTick)
    );

    assign abortTick = shortTimeoutEnable ? shortTick : longTick;

    // ==========================================================
    // Utility register
    logic [3:0] cap_q, cap_d;
    logic [3:0] hold_q, hold_d;
    logic [3:0] abortLim_q, abortLim_d;
    logic [1:0] map_q, map_d;
    logic narrow_q, narrow_d;
    logic [31:0] rd_q, rd_d;
    logic ack_q, ack_d;
    logic hit;
    logic [31:0] regWord;

    assign hit = regSel && (regOffset == UTIL_OFFSET);

    always_comb begin
        regWord = ZERO_WORD;
        regWord[CAP_POS+:4] = cap_q;
        regWord[HOLD_POS+:4] = hold_q;
        regWord[ABORT_POS+:4] = abortLim_q;
        regWord[MAP_POS+:2] = map_q;
        regWord[NARROW_POS] = narrow_q;
        cap_d = cap_q;
        hold_d = hold_q;
        abortLim_d = abortLim_q;
        map_d = map_q;
        narrow_d = narrow_q;
        rd_d = rd_q;
        ack_d = regSel;
        if (hit && regWr) begin
            cap_d = regWrData[CAP_POS+:4];
            hold_d = regWrData[HOLD_POS+:4];
            abortLim_d = regWrData[ABORT_POS+:4];
            map_d = regWrData[MAP_POS+:2];
            narrow_d = regWrData[NARROW_POS];
        end
        if (regSel && !regWr) begin
            rd_d = hit ? regWord : ZERO_WORD;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cap_q <= CAP_RESET;
            hold_q <= HOLD_RESET;
            abortLim_q <= ABORT_RESET;
            map_q <= MAP_RESET;
            narrow_q <= NARROW_RESET;
            rd_q <= ZERO_WORD;
            ack_q <= 1'b0;
        end else begin
            cap_q <= cap_d;
            hold_q <= hold_d;
            abortLim_q <= abortLim_d;
            map_q <= map_d;
            narrow_q <= narrow_d;
            rd_q <= rd_d;
            ack_q <= ack_d;
        end
    end

    assign regRdData = rd_q;
    assign regAck = ack_q;
    assign map_mode_select = map_mode_t'(map_q);
    assign narrow_address_enable = narrow_q;

    // ==========================================================
    // Interlocked read lockout
    // A retry that arrives while the lock is released is not counted:
    // the line stays free until a read completes.
    lock_state_t lk_q, lk_d;
    logic [3:0] tries_q, tries_d;
    logic [3:0] holdCnt_q, holdCnt_d;
    logic holdN_q, holdN_d;

    always_comb begin
        lk_d = lk_q;
        tries_d = tries_q;
        holdCnt_d = holdCnt_q;
        case (lk_q)
            LK_IDLE: begin
                holdCnt_d = 4'h0;
                if (interlockedRdDone) begin
                    tries_d = 4'h0;
                end else if (interlockedRdRetry) begin
                    if (tries_q + 4'h1 >= stepCount(cap_q)) begin
                        lk_d = LK_HOLD;
                        tries_d = 4'h0;
                    end else begin
                        tries_d = tries_q + 4'h1;
                    end
                end
            end
            LK_HOLD: begin
                if (interlockedRdDone) begin
                    lk_d = LK_IDLE;
                end else if (longTick) begin
                    holdCnt_d = holdCnt_q + 4'h1;
                    if (holdCnt_q + 4'h1 >= stepCount(hold_q)) begin
                        lk_d = LK_RELEASED;
                    end
                end
            end
            LK_RELEASED: begin
                if (interlockedRdDone) begin
                    lk_d = LK_IDLE;
                end
            end
            default: begin
                lk_d = LK_IDLE;
            end
        endcase
        holdN_d = (lk_d != LK_HOLD);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lk_q <= LK_IDLE;
            tries_q <= 4'h0;
            holdCnt_q <= 4'h0;
            holdN_q <= 1'b1;
        end else begin
            lk_q <= lk_d;
            tries_q <= tries_d;
            holdCnt_q <= holdCnt_d;
            holdN_q <= holdN_d;
        end
    end

    assign bus_hold_off_n = holdN_q;

    // ==========================================================
    // Transaction abort timer
    logic run_q, run_d;
    logic [3:0] txCnt_q, txCnt_d;
    logic abort_q, abort_d;
    logic flag_q, flag_d;

    always_comb begin
        run_d = run_q;
        txCnt_d = txCnt_q;
        abort_d = 1'b0;
        if (txnEnd) begin
            run_d = 1'b0;
        end else if (txnStart) begin
            run_d = 1'b1;
            txCnt_d = 4'h0;
        end else if (run_q && abortTick) begin
            txCnt_d = txCnt_q + 4'h1;
            if (txCnt_q + 4'h1 >= stepCount(abortLim_q)) begin
                run_d = 1'b0;
                abort_d = 1'b1;
            end
        end
        // Set wins over clear so an expiry is never lost
        flag_d = abort_d | (flag_q & ~expiredFlagClear);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            run_q <= 1'b0;
            txCnt_q <= 4'h0;
            abort_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            run_q <= run_d;
            txCnt_q <= txCnt_d;
            abort_q <= abort_d;
            flag_q <= flag_d;
        end
    end

    assign txnAbort = abort_q;
    assign transaction_expired_flag = flag_q;

    // ==========================================================
    // Narrow address masking
    logic [ADDR_W-1:0] addr_q, addr_d;

    always_comb begin
        addr_d = xlatAddrIn;
        if (narrow_q && (map_q == MAP_PAGE512)) begin
            addr_d[ADDR_W-1 -: NARROW_MASK_BITS] = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            addr_q <= '0;
        end else begin
            addr_q <= addr_d;
        end
    end

    assign xlatAddrOut = addr_q;
endmodule : bus_timeout_lockout_utility

//--- dv/bus_timeout_lockout_utility_asserts.sv
// Assertion checker for the utility register block
`timescale 1ns/1ps
module bus_timeout_lockout_utility_asserts #(
    parameter int LONG_CYCLES = 20
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register access
    input wire logic regSel,
    input wire logic regWr,
    input wire logic [7:0] regOffset,
    input wire logic [31:0] regWrData,
    input wire logic [31:0] regRdData,
    input wire logic regAck,
    // Lockout and abort timer
    input wire logic interlockedRdRetry,
    input wire logic bus_hold_off_n,
    input wire logic txnAbort,
    input wire logic transaction_expired_flag,
    input wire logic expiredFlagClear,
    // Translation
    input wire logic [utility_pkg::ADDR_W-1:0] xlatAddrIn,
    input wire logic [utility_pkg::ADDR_W-1:0] xlatAddrOut,
    input wire utility_pkg::map_mode_t map_mode_select,
    input wire logic narrow_address_enable
);
    import utility_pkg::*;
    // ==========================================================
    // Properties
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_ack_follows: assert property (regSel |=> regAck)
        else $error("ack missing after access");
    a_ack_only: assert property (!regSel |=> !regAck)
        else $error("ack without access");
    a_reserved_zero: assert property (regAck && !$past(regWr)
        |-> regRdData[16:0] == 17'h0_0000)
        else $error("reserved bits read nonzero");
    a_map_write: assert property (regSel && regWr
        && regOffset == 8'h20 |=> map_mode_select == $past(regWrData[19:18]))
        else $error("map mode not written");
    a_narrow_write: assert property (regSel && regWr
        && regOffset == 8'h20
        |=> narrow_address_enable == $past(regWrData[17]))
        else $error("narrow bit not written");
    // Output uses the mode held before the edge that registers it
    a_xlat_mask: assert property (!$past(sys_rst) |-> xlatAddrOut ==
        ($past(narrow_address_enable) && $past(map_mode_select) == MAP_PAGE512
        ? {5'h00, $past(xlatAddrIn[34:0])} : $past(xlatAddrIn)))
        else $error("translated address mask wrong");
    a_reset_vals: assert property ($past(sys_rst) |->
        map_mode_select == MAP_NONE && !narrow_address_enable
        && bus_hold_off_n)
        else $error("reset values wrong");
    a_lock_cause: assert property (!$past(sys_rst)
        && $fell(bus_hold_off_n) |-> $past(interlockedRdRetry))
        else $error("lockout without retry");
    a_abort_flag: assert property (txnAbort
        |-> transaction_expired_flag ##1 !txnAbort)
        else $error("abort pulse or flag wrong");
    a_flag_sticky: assert property (!$past(sys_rst)
        && $fell(transaction_expired_flag) |-> $past(expiredFlagClear))
        else $error("flag cleared without request");
endmodule : bus_timeout_lockout_utility_asserts

bind bus_timeout_lockout_utility bus_timeout_lockout_utility_asserts
    #(.LONG_CYCLES(LONG_CYCLES)) chkI (.*);

//--- dv/backplane_node.sv
// Backplane node model driving lockout and timer events
`timescale 1ns/1ps
module backplane_node (
    // Clock
    input wire logic clock,
    // Events toward the adapter
    output logic interlockedRdRetry,
    output logic interlockedRdDone,
    output logic txnStart,
    output logic txnEnd
);
    logic [3:0] ev = 4'h0;
    assign {txnEnd, txnStart, interlockedRdDone, interlockedRdRetry} = ev;
    // One-cycle pulses launched after an edge, seen at exactly one edge
    task automatic fire(input logic [3:0] e);
        @(posedge clock);
        ev <= e;
        @(posedge clock);
        ev <= 4'h0;
    endtask : fire
endmodule : backplane_node

//--- dv/bus_timeout_lockout_utility_tb_top.sv
// Self-checking bench for the utility register block
`timescale 1ns/1ps
module bus_timeout_lockout_utility_tb_top;
    import utility_pkg::*;
    // ==========================================================
    // Signals
    localparam int LC = 20;
    logic clock, sys_rst, regSel, regWr, shortTimeoutEnable;
    logic expiredFlagClear, regAck, bus_hold_off_n, txnAbort;
    logic transaction_expired_flag, narrow_address_enable;
    logic interlockedRdRetry, interlockedRdDone, txnStart, txnEnd;
    logic [7:0] regOffset;
    logic [31:0] regWrData, regRdData, d;
    logic [39:0] x;
    logic [ADDR_W-1:0] xlatAddrIn, xlatAddrOut;
    map_mode_t map_mode_select;
    logic [3:0] caps [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hF};
    logic [3:0] holds [3] = '{4'h0, 4'h3, 4'hF};
    int error_cnt = 0, n_compared = 0, c, n, t;

    bus_timeout_lockout_utility #(.LONG_CYCLES(LC)) dut (.clock, .sys_rst,
        .regSel, .regWr, .regOffset, .regWrData, .regRdData, .regAck,
        .shortTimeoutEnable, .interlockedRdRetry, .interlockedRdDone,
        .bus_hold_off_n, .txnStart, .txnEnd, .txnAbort,
        .transaction_expired_flag, .expiredFlagClear, .xlatAddrIn,
        .xlatAddrOut, .map_mode_select, .narrow_address_enable);
    backplane_node node (.clock, .interlockedRdRetry, .interlockedRdDone,
        .txnStart, .txnEnd);

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ==========================================================
    // Tasks
    task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic rng(string nm, int lo, int hi);
        n_compared++;
        if (c < lo || c > hi) begin
            error_cnt++;
            $display("unexpected %s exp %0d..%0d got %0d", nm, lo, hi, c);
        end
    endtask : rng
    task automatic acc(logic w, logic [7:0] a, logic [31:0] v);
        @(posedge clock);
        regSel <= 1'b1;
        regWr <= w;
        regOffset <= a;
        regWrData <= v;
        @(posedge clock);
        regSel <= 1'b0;
        @(negedge clock);
        chk("ack", 1, regAck);
        d = regRdData;
    endtask : acc
    // Waits for lockout release (w 0) or an abort pulse (w 1)
    task automatic upto(int w, int lim);
        c = 0;
        while (c < lim && (w == 0 ? bus_hold_off_n : txnAbort) !== 1'b1) begin
            @(negedge clock);
            c++;
        end
        if (c >= lim) begin
            error_cnt++;
            $display("unexpected wait %0d exp event got timeout", w);
            results();
        end
    endtask : upto
    task automatic results();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    // ==========================================================
    // Scenarios
    initial begin
        sys_rst = 1'b1;
        regSel = 1'b0;
        regWr = 1'b0;
        regOffset = 8'h00;
        regWrData = 32'h0000_0000;
        shortTimeoutEnable = 1'b0;
        expiredFlagClear = 1'b0;
        xlatAddrIn = 40'hFF_FFFF_FFFF;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        acc(0, 8'h20, 0);
        chk("reset word", 32'h43F0_0000, d);
        acc(1, 8'h20, 32'hFFFF_FFFF);
        acc(0, 8'h20, 0);
        chk("all ones", 32'hFFFE_0000, d);
        acc(1, 8'h24, 0);
        acc(0, 8'h20, 0);
        chk("unmapped write", 32'hFFFE_0000, d);
        acc(0, 8'h24, 0);
        chk("unmapped read", 0, d);
        for (int m = 0; m < 4; m++) begin
            x = {8'hF8, 24'h5A_5A5A, 8'(m)};
            @(posedge clock);
            xlatAddrIn <= x;
            acc(1, 8'h20, {12'h43F, m[1:0], 1'b1, 17'h0_0000});
            @(negedge clock);
            chk("map", m, map_mode_select);
            chk("narrow", 1, narrow_address_enable);
            x[39:35] = m == 1 ? 5'h00 : x[39:35];
            chk("xlat", x, xlatAddrOut);
        end
        // Mid-run reset must bring map and narrow back to their power-up values; the other fields already hold theirs
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        acc(0, 8'h20, 0);
        chk("reset again", 32'h43F0_0000, d);
        foreach (caps[i]) begin
            n = caps[i] < 2 ? 1 : caps[i];
            acc(1, 8'h20, {caps[i], 8'h1F, 20'h0_0000});
            for (int k = 1; k <= n; k++) begin
                node.fire(4'h1);
                @(negedge clock);
                chk("hold off", k != n, bus_hold_off_n);
            end
            node.fire(4'h2);
            @(negedge clock);
            chk("after done", 1, bus_hold_off_n);
        end
        foreach (holds[i]) begin
            n = holds[i] < 1 ? 1 : holds[i];
            acc(1, 8'h20, {4'h1, holds[i], 24'hF0_0000});
            node.fire(4'h1);
            @(negedge clock);
            upto(0, 400);
            rng("hold time", (n - 1) * LC, n * LC + 2);
            node.fire(4'h2);
        end
        for (int s = 0; s < 4; s++) begin
            n = s[0] ? 2 : 1;
            t = s[1] ? 2560 : LC;
            @(posedge clock);
            shortTimeoutEnable <= s[1];
            acc(1, 8'h20, {8'h43, 2'b00, s[0], 1'b0, 20'h0_0000});
            node.fire(4'h4);
            @(negedge clock);
            upto(1, 6000);
            rng("abort time", (n - 1) * t, n * t + 2);
            chk("flag", 1, transaction_expired_flag);
            @(posedge clock);
            expiredFlagClear <= 1'b1;
            @(posedge clock);
            expiredFlagClear <= 1'b0;
            @(negedge clock);
            chk("flag clear", 0, transaction_expired_flag);
        end
        @(posedge clock);
        shortTimeoutEnable <= 1'b0;
        acc(1, 8'h20, 32'h4310_0000);
        node.fire(4'h4);
        node.fire(4'h8);
        repeat (3 * LC) begin
            @(negedge clock);
            chk("stopped", 0, txnAbort);
        end
        results();
    end
endmodule : bus_timeout_lockout_utility_tb_top
